// ===== design/pmsc_defs.svh
// Purpose: Offsets, field positions, reset values and timing constants
//          of the power mode and strap controller.
// Assumes: Included by bare name by every design file that needs it.
// Notes:   Definitions only.
`ifndef PMSC_DEFS_SVH
`define PMSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the host register port.
// ----------------------------------------------------------------------
`define PMSC_OFS_CHIP_CFG   8'h08
`define PMSC_OFS_GRR_WAKE   8'h26
`define PMSC_OFS_RXFP_CTRL  8'h86
`define PMSC_OFS_IER_MASK   8'h90
`define PMSC_OFS_PME_CTRL   8'hD4
`define PMSC_OFS_SLEEP_WAKE 8'hD6

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PMSC_CFG_BUS8_BIT   6
`define PMSC_CFG_BUS16_BIT  7
`define PMSC_CFG_EEPROM_BIT 9
`define PMSC_CFG_BIGEND_BIT 10
`define PMSC_RXFP_ENDIAN    11
`define PMSC_PME_MODE_HI    1
`define PMSC_PME_MODE_LO    0
`define PMSC_PME_TO_NORMAL  6
`define PMSC_PME_AUTO_WAKE  7
`define PMSC_PME_PIN_EN     8
`define PMSC_IER_ENERGY     2
`define PMSC_GO_SLEEP_HI    7
`define PMSC_GO_SLEEP_LO    0
`define PMSC_WAKE_UP_HI     15
`define PMSC_WAKE_UP_LO     8

// ----------------------------------------------------------------------
// Reset values and widths.
// ----------------------------------------------------------------------
`define PMSC_REG_RST        16'h0000
`define PMSC_TIME_W         8
`define PMSC_UNITS_W        9
`define PMSC_PRESC_W        17

// ----------------------------------------------------------------------
// Timing: clock period and timer unit, both in nanoseconds.
// ----------------------------------------------------------------------
`define PMSC_CLK_PERIOD_NS  8
`define PMSC_TICK_UNIT_NS   1000000
`define PMSC_TICK_CYCLES    (`PMSC_TICK_UNIT_NS / `PMSC_CLK_PERIOD_NS)

`endif

// ===== design/pmsc_pkg.sv
// Purpose: Types shared by the power mode and strap controller.
// Assumes: Nothing beyond the defs header.
// Notes:   Mode codes follow the two-bit mode field.
package pmsc_pkg;

  // Operating modes held in the mode field.
  typedef enum logic [1:0] {
    PMSC_NORMAL   = 2'h0,
    PMSC_ENERGY   = 2'h1,
    PMSC_SOFT_PD  = 2'h2,
    PMSC_PWR_SAVE = 2'h3
  } pmsc_mode_e;

  // Power states inside energy detect mode.
  typedef enum logic {
    PMSC_ST_NORM = 1'h0,
    PMSC_ST_LOW  = 1'h1
  } pmsc_state_e;

endpackage

// ===== design/pmsc_dwell_timer.sv
// Purpose: Measures how long a condition has held, in timer units.
// Assumes: run drops whenever the measured condition breaks.
// Notes:   expiredR is high while the dwell exceeds the limit.
`include "pmsc_defs.svh"

module pmsc_dwell_timer #(
  parameter int TICK_CYCLES = `PMSC_TICK_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    run,
  input  wire logic [`PMSC_TIME_W-1:0] limit,
  output logic                         expiredR
);

  logic [`PMSC_PRESC_W-1:0] prescR;  // Cycles within the current unit.
  logic [`PMSC_UNITS_W-1:0] unitsR;  // Whole units elapsed, saturating.
  logic                     tick;    // End of one timer unit.

  assign tick = (prescR == `PMSC_PRESC_W'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Prescaler and unit counter.
  // ----------------------------------------------------------------------
  // Both restart whenever the condition breaks, so the dwell is continuous.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      prescR <= '0;
      unitsR <= '0;
    end else if (tick) begin
      prescR <= '0;
      // Saturate so a long dwell never wraps back below the limit.
      if (!(&unitsR)) begin
        unitsR <= unitsR + `PMSC_UNITS_W'(1);
      end
    end else begin
      prescR <= prescR + `PMSC_PRESC_W'(1);
    end
  end

  // A dwell counts only when strictly longer than the limit.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      expiredR <= 1'b0;
    end else begin
      expiredR <= run && (unitsR > {1'b0, limit});
    end
  end

endmodule

// ===== design/pmsc_power_mode_strap_ctrl.sv
// Purpose: Strap latching, power mode selection, block gating and
//          energy detect sleep and wake control.
// Assumes: Host register port is synchronous to clk_sys; a read or write
//          strobe lasts one cycle.
// Notes:   Read data appears one cycle after the read strobe.
`include "pmsc_defs.svh"

// Overview of operation
// - Latch bus-width strap into configuration bits 6/7
// - Latch EEPROM strap into configuration bit 9
// - Latch endian strap into configuration bit 10
// - Default strap lets bit 11 pick endian
// - Straps are inputs in reset, outputs otherwise
// - Bits 1:0 select one of four modes
// - Gate PLL, PHY, MAC, host per mode
// - Reset leaves normal mode, PLL, PHY, MAC and host running
// - Host writes mode field to change mode
// - Writing 01 enters energy detect mode
// - Sleep after no energy beyond go-sleep time
// - Low power keeps only energy detection
// - Wake when energy persists beyond wake time
// - Auto-wake to normal state or mode
// - Energy event drives wake output if enabled
// - Energy event raises interrupt if enabled
// - Host read of reset register wakes device
// - Normal power state can pass frames
// - Writing 10 stops everything, registers kept
// - Soft power down left only by reset-register read
// - Power saving needs autoneg, no cable, PHY bit
module pmsc_power_mode_strap_ctrl #(
  parameter int TICK_CYCLES = `PMSC_TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regRd,
  input  wire logic        regWr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata_r,
  input  wire logic        busWidthStrapIn,
  output logic             busWidthStrapOut_r,
  output logic             busWidthStrapOe_r,
  input  wire logic        eepromStrapIn,
  output logic             eepromStrapOut_r,
  output logic             eepromStrapOe_r,
  input  wire logic        endianStrapIn,
  output logic             endianStrapOut_r,
  output logic             endianStrapOe_r,
  input  wire logic [2:0]  strapDriveVal,
  input  wire logic        cableEnergy,
  input  wire logic        autoNegEnabled,
  input  wire logic        cableConnected,
  input  wire logic        phySpecialCtrlPs,
  output logic             pllEn_r,
  output logic             phyEn_r,
  output logic             phyRxTrim_r,
  output logic             energyDetEn_r,
  output logic             macEn_r,
  output logic             hostIfEn_r,
  output logic             bigEndian_r,
  output logic             wakeEventOut_r,
  output logic             irqOut_r
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [15:0]           chipStrapCfgR;   // Latched strap values.
  logic [15:0]           globalResetR;    // Plain storage word.
  logic [15:0]           rxFramePtrR;     // Holds the endian select.
  logic [15:0]           intEnableR;      // Interrupt enable mask.
  logic [15:0]           pmeCtrlR;        // Mode and wake controls.
  logic [15:0]           sleepWakeR;      // Go-sleep and wake-up times.
  pmsc_pkg::pmsc_state_e edStateR;        // Energy detect power state.
  logic                  energyEventR;    // Sticky energy detect event.

  // ----------------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------------
  pmsc_pkg::pmsc_mode_e mode;
  logic hostOpen;   // Host may use every register.
  logic grrRead;    // Wake command from the host.
  logic sleepRun;   // No energy while awake in energy detect mode.
  logic wakeRun;    // Energy present while asleep.
  logic sleepExp;
  logic wakeExp;
  logic wakeFire;   // Wake condition reached this cycle.
  logic psActive;   // Power saving really in effect.
  logic [5:0] gate; // {pll, phy, trim, energy, mac, host}.

  // Address match, used by both the read and the write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Block enables for a mode and power state.
  function automatic logic [5:0] gateFor(
    input pmsc_pkg::pmsc_mode_e  m,
    input pmsc_pkg::pmsc_state_e s,
    input logic                  ps
  );
    case (m)
      pmsc_pkg::PMSC_SOFT_PD:  gateFor = 6'h00;
      pmsc_pkg::PMSC_ENERGY:
        gateFor = (s == pmsc_pkg::PMSC_ST_LOW) ? 6'h04
                                               : 6'h37;
      pmsc_pkg::PMSC_PWR_SAVE:
        gateFor = ps ? 6'h3B : 6'h33;
      default:                 gateFor = 6'h33;
    endcase
  endfunction

  assign mode     = pmsc_pkg::pmsc_mode_e'(
                      pmeCtrlR[`PMSC_PME_MODE_HI:`PMSC_PME_MODE_LO]);
  // Soft power down and the low power state leave only the wake path.
  assign hostOpen = (mode != pmsc_pkg::PMSC_SOFT_PD) &&
                    !(mode == pmsc_pkg::PMSC_ENERGY &&
                      edStateR == pmsc_pkg::PMSC_ST_LOW);
  assign grrRead  = regRd && hit(regAddr, `PMSC_OFS_GRR_WAKE);
  assign psActive = autoNegEnabled && !cableConnected &&
                    phySpecialCtrlPs;
  assign sleepRun = (mode == pmsc_pkg::PMSC_ENERGY) &&
                    (edStateR == pmsc_pkg::PMSC_ST_NORM) && !cableEnergy;
  assign wakeRun  = (mode == pmsc_pkg::PMSC_ENERGY) &&
                    (edStateR == pmsc_pkg::PMSC_ST_LOW) && cableEnergy;
  assign wakeFire = wakeRun && wakeExp;
  assign gate     = gateFor(mode, edStateR, psActive);

  // ----------------------------------------------------------------------
  // Dwell timers.
  // ----------------------------------------------------------------------
  // Both share one unit so software sees a single time base.
  pmsc_dwell_timer #(.TICK_CYCLES(TICK_CYCLES)) uSleepTimer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (sleepRun),
    .limit    (sleepWakeR[`PMSC_GO_SLEEP_HI:`PMSC_GO_SLEEP_LO]),
    .expiredR (sleepExp)
  );

  pmsc_dwell_timer #(.TICK_CYCLES(TICK_CYCLES)) uWakeTimer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (wakeRun),
    .limit    (sleepWakeR[`PMSC_WAKE_UP_HI:`PMSC_WAKE_UP_LO]),
    .expiredR (wakeExp)
  );

  // ----------------------------------------------------------------------
  // Strap pins.
  // ----------------------------------------------------------------------
  // Latched while reset is held; the pins float during reset so the
  // board pulls decide the value, then drive their normal function.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chipStrapCfgR <= `PMSC_REG_RST;
      chipStrapCfgR[`PMSC_CFG_BUS16_BIT]  <= busWidthStrapIn;
      chipStrapCfgR[`PMSC_CFG_BUS8_BIT]   <= !busWidthStrapIn;
      chipStrapCfgR[`PMSC_CFG_EEPROM_BIT] <= eepromStrapIn;
      chipStrapCfgR[`PMSC_CFG_BIGEND_BIT] <= endianStrapIn;
    end
  end

  // Output enables stay low through reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busWidthStrapOe_r  <= 1'b0;
      eepromStrapOe_r    <= 1'b0;
      endianStrapOe_r    <= 1'b0;
      busWidthStrapOut_r <= 1'b0;
      eepromStrapOut_r   <= 1'b0;
      endianStrapOut_r   <= 1'b0;
    end else begin
      busWidthStrapOe_r  <= 1'b1;
      eepromStrapOe_r    <= 1'b1;
      endianStrapOe_r    <= 1'b1;
      busWidthStrapOut_r <= strapDriveVal[0];
      eepromStrapOut_r   <= strapDriveVal[1];
      endianStrapOut_r   <= strapDriveVal[2];
    end
  end

  // A big endian strap wins; otherwise software picks the order.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bigEndian_r <= 1'b0;
    end else begin
      bigEndian_r <= chipStrapCfgR[`PMSC_CFG_BIGEND_BIT] ||
                     rxFramePtrR[`PMSC_RXFP_ENDIAN];
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers.
  // ----------------------------------------------------------------------
  // Writes are dropped while the host interface is closed.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      globalResetR <= `PMSC_REG_RST;
      rxFramePtrR  <= `PMSC_REG_RST;
      intEnableR   <= `PMSC_REG_RST;
      sleepWakeR   <= `PMSC_REG_RST;
    end else if (regWr && hostOpen) begin
      if (hit(regAddr, `PMSC_OFS_GRR_WAKE))   globalResetR <= regWdata;
      if (hit(regAddr, `PMSC_OFS_RXFP_CTRL))  rxFramePtrR  <= regWdata;
      if (hit(regAddr, `PMSC_OFS_IER_MASK))   intEnableR   <= regWdata;
      if (hit(regAddr, `PMSC_OFS_SLEEP_WAKE)) sleepWakeR   <= regWdata;
    end
  end

  // Mode and wake control; hardware may also force the mode to normal.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pmeCtrlR <= `PMSC_REG_RST;
    end else if (mode == pmsc_pkg::PMSC_SOFT_PD && grrRead) begin
      pmeCtrlR[`PMSC_PME_MODE_HI:`PMSC_PME_MODE_LO] <=
        pmsc_pkg::PMSC_NORMAL;
    end else if (wakeFire && pmeCtrlR[`PMSC_PME_AUTO_WAKE] &&
                 pmeCtrlR[`PMSC_PME_TO_NORMAL]) begin
      pmeCtrlR[`PMSC_PME_MODE_HI:`PMSC_PME_MODE_LO] <=
        pmsc_pkg::PMSC_NORMAL;
    end else if (regWr && hostOpen &&
                 hit(regAddr, `PMSC_OFS_PME_CTRL)) begin
      pmeCtrlR <= regWdata;
    end
  end

  // ----------------------------------------------------------------------
  // Energy detect power state.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      edStateR <= pmsc_pkg::PMSC_ST_NORM;
    end else begin
      case (edStateR)
        pmsc_pkg::PMSC_ST_NORM: begin
          // Fall asleep only after a full go-sleep dwell without energy.
          if (sleepRun && sleepExp) begin
            edStateR <= pmsc_pkg::PMSC_ST_LOW;
          end
        end
        pmsc_pkg::PMSC_ST_LOW: begin
          if (mode != pmsc_pkg::PMSC_ENERGY) begin
            edStateR <= pmsc_pkg::PMSC_ST_NORM;
          end else if (wakeFire && pmeCtrlR[`PMSC_PME_AUTO_WAKE]) begin
            edStateR <= pmsc_pkg::PMSC_ST_NORM;
          end else if (grrRead) begin
            edStateR <= pmsc_pkg::PMSC_ST_NORM;
          end
        end
        default: edStateR <= pmsc_pkg::PMSC_ST_NORM;
      endcase
    end
  end

  // Sticky event; a new wake in the clearing cycle wins over the clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      energyEventR <= 1'b0;
    end else if (wakeFire) begin
      energyEventR <= 1'b1;
    end else if (grrRead) begin
      energyEventR <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {pllEn_r, phyEn_r, phyRxTrim_r, energyDetEn_r, macEn_r, hostIfEn_r}
        <= 6'h33;
    end else begin
      {pllEn_r, phyEn_r, phyRxTrim_r, energyDetEn_r, macEn_r, hostIfEn_r}
        <= gate;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wakeEventOut_r <= 1'b0;
      irqOut_r       <= 1'b0;
    end else begin
      wakeEventOut_r <= energyEventR && pmeCtrlR[`PMSC_PME_PIN_EN];
      irqOut_r       <= energyEventR && intEnableR[`PMSC_IER_ENERGY];
    end
  end

  // Read mux; 0x26 always reads; other registers read zero while closed, as do unmapped addresses.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata_r <= `PMSC_REG_RST;
    end else if (regRd) begin
      regRdata_r <= `PMSC_REG_RST;
      if (hit(regAddr, `PMSC_OFS_GRR_WAKE))   regRdata_r <= globalResetR;
      if (hostOpen) begin
        if (hit(regAddr, `PMSC_OFS_CHIP_CFG))   regRdata_r <= chipStrapCfgR;
        if (hit(regAddr, `PMSC_OFS_RXFP_CTRL))  regRdata_r <= rxFramePtrR;
        if (hit(regAddr, `PMSC_OFS_IER_MASK))   regRdata_r <= intEnableR;
        if (hit(regAddr, `PMSC_OFS_PME_CTRL))   regRdata_r <= pmeCtrlR;
        if (hit(regAddr, `PMSC_OFS_SLEEP_WAKE)) regRdata_r <= sleepWakeR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_mode_after_reset: assert property ($rose(rst_n) |->
    mode == pmsc_pkg::PMSC_NORMAL && pllEn_r && hostIfEn_r)
    else $error("Mode or gating wrong after reset.");
  a_strap_drive: assert property ($past(rst_n) |->
    busWidthStrapOe_r && eepromStrapOe_r && endianStrapOe_r)
    else $error("Strap pin not driving after reset.");
  a_strap_held: assert property ($past(rst_n) |->
    $stable(chipStrapCfgR) && (chipStrapCfgR[`PMSC_CFG_BUS8_BIT] !=
    chipStrapCfgR[`PMSC_CFG_BUS16_BIT]))
    else $error("Strap configuration changed or inconsistent.");
  a_endian_sel: assert property ($past(rst_n) |->
    bigEndian_r == ($past(chipStrapCfgR[`PMSC_CFG_BIGEND_BIT]) ||
    $past(rxFramePtrR[`PMSC_RXFP_ENDIAN])))
    else $error("Endian output disagrees with strap and select.");
  a_soft_pd_off: assert property (mode == pmsc_pkg::PMSC_SOFT_PD
    ##1 mode == pmsc_pkg::PMSC_SOFT_PD |-> !pllEn_r && !phyEn_r && !macEn_r)
    else $error("Block left running in soft power down.");
  a_soft_pd_exit: assert property (mode == pmsc_pkg::PMSC_SOFT_PD &&
    grrRead |=> mode == pmsc_pkg::PMSC_NORMAL ##1 pllEn_r && hostIfEn_r)
    else $error("Reset register read did not leave soft power down.");
  a_soft_pd_hold: assert property (mode == pmsc_pkg::PMSC_SOFT_PD &&
    !grrRead |=> mode == pmsc_pkg::PMSC_SOFT_PD)
    else $error("Soft power down left without wake command.");
  a_low_gating: assert property (edStateR == pmsc_pkg::PMSC_ST_LOW &&
    $past(edStateR) == pmsc_pkg::PMSC_ST_LOW |->
    energyDetEn_r && !pllEn_r && !macEn_r && !hostIfEn_r)
    else $error("Low power state left circuitry enabled.");
  a_sleep_cause: assert property (
    edStateR == pmsc_pkg::PMSC_ST_NORM ##1 edStateR == pmsc_pkg::PMSC_ST_LOW
    |-> $past(sleepRun) && $past(sleepExp))
    else $error("Entered low power without go-sleep dwell.");
  a_auto_wake: assert property (wakeFire &&
    pmeCtrlR[`PMSC_PME_AUTO_WAKE] |=> edStateR == pmsc_pkg::PMSC_ST_NORM)
    else $error("Auto wake did not restore normal power state.");
  a_host_wake: assert property (edStateR == pmsc_pkg::PMSC_ST_LOW &&
    grrRead |=> edStateR == pmsc_pkg::PMSC_ST_NORM)
    else $error("Host wake command ignored.");
  a_wake_pin: assert property (wakeFire && pmeCtrlR[`PMSC_PME_PIN_EN]
    |=> ##1 wakeEventOut_r)
    else $error("Wake event output not raised.");
  a_irq_out: assert property (wakeFire && intEnableR[`PMSC_IER_ENERGY]
    |=> ##1 irqOut_r)
    else $error("Energy interrupt not raised.");

  c_sleep: cover property (edStateR == pmsc_pkg::PMSC_ST_LOW);
  c_auto_wake: cover property (wakeFire && pmeCtrlR[`PMSC_PME_AUTO_WAKE]);
  c_pd_exit: cover property (mode == pmsc_pkg::PMSC_SOFT_PD && grrRead);
  c_ps_live: cover property (mode == pmsc_pkg::PMSC_PWR_SAVE && psActive);

endmodule

// ===== test/pmsc_host_model.sv
// Purpose: Host processor model driving the register port.
// Assumes: Strobes change on the falling clock edge.
// Notes:   One idle cycle separates accesses; released lines invert.
module pmsc_host_model (
  input  wire logic        clk_sys,
  output logic      [7:0]  regAddr,
  output logic             regRd,
  output logic             regWr,
  output logic      [15:0] regWdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Access tasks.
  // ------------------------------------------------------------------
  // The bus starts idle so nothing is taken during reset.
  initial begin
    regAddr  = 8'h00;
    regRd    = 1'b0;
    regWr    = 1'b0;
    regWdata = 16'h0000;
  end

  // One-cycle write strobe; this is how the mode field is changed.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr  = a;
    regWdata = d;
    regWr    = 1'b1;
    @(negedge clk_sys);
    regWr    = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // One-cycle read strobe; a read of 0x26 is the only wake path out of soft power down.
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    regAddr = a;
    regRd   = 1'b1;
    @(negedge clk_sys);
    regRd   = 1'b0;
    regAddr = ~a;
  endtask
endmodule

// ===== test/power_mode_strap_ctrl_bench.sv
// Purpose: Self-checking bench for the power mode and strap controller.
// Assumes: Timer unit shortened to 4 clocks.
// Notes:   Read results are noted in a queue and checked as they land.
module power_mode_strap_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Signals.
  // ------------------------------------------------------------------
  logic        clk_sys, rst_n, rdPend, cableEnergy, autoNeg, cableConn;
  logic        phyPs, bigEndian_r, wakeEventOut_r, irqOut_r, regRd, regWr;
  logic [2:0]  drv, sDrv, sOut, sOe, pin;
  logic [5:0]  en;                 // pll phy trim energyDet mac host.
  logic [7:0]  regAddr, obs;
  logic [15:0] regWdata, regRdata_r;
  logic [15:0] expQ[$];            // Expected read words, oldest first.
  int          num_errors, comparisons, seed;

  // Each strap wire is the device's drive when enabled, else the strap.
  assign pin = (sOe & sOut) | (~sOe & drv);
  assign obs = {wakeEventOut_r, irqOut_r, en};

  pmsc_host_model pmsc_host_model_i (.clk_sys(clk_sys), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .regWdata(regWdata));

  pmsc_power_mode_strap_ctrl #(.TICK_CYCLES(4)) pmsc_power_mode_strap_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regWdata(regWdata), .regRdata_r(regRdata_r),
    .busWidthStrapIn(pin[0]), .busWidthStrapOut_r(sOut[0]),
    .busWidthStrapOe_r(sOe[0]), .eepromStrapIn(pin[1]),
    .eepromStrapOut_r(sOut[1]), .eepromStrapOe_r(sOe[1]),
    .endianStrapIn(pin[2]), .endianStrapOut_r(sOut[2]),
    .endianStrapOe_r(sOe[2]), .strapDriveVal(sDrv),
    .cableEnergy(cableEnergy), .autoNegEnabled(autoNeg),
    .cableConnected(cableConn), .phySpecialCtrlPs(phyPs), .pllEn_r(en[5]),
    .phyEn_r(en[4]), .phyRxTrim_r(en[3]), .energyDetEn_r(en[2]),
    .macEn_r(en[1]), .hostIfEn_r(en[0]), .bigEndian_r(bigEndian_r),
    .wakeEventOut_r(wakeEventOut_r), .irqOut_r(irqOut_r));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------
  // Checking.
  // ------------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Read data lands one edge after the strobe, so look half a cycle on.
  always @(posedge clk_sys) rdPend <= regRd;
  always @(negedge clk_sys) begin
    if (rdPend === 1'b1) begin
      check("regRdata_r", regRdata_r, expQ.pop_front());
    end
  end

  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    pmsc_host_model_i.rd(a);
  endtask

  // Bounded wait for masked outputs; running out ends the run.
  task automatic waitObs(input logic [7:0] m, v);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk_sys);
      if ((obs & m) === v) break;
    end
    check("outputs", {8'h00, obs & m}, {8'h00, v});
    if (k == 300) finish_test();
  endtask

  task automatic doReset();
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("strap oe in reset", {13'h0, sOe}, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check("strap oe", {13'h0, sOe}, 16'h0007);
    check("strap out", {13'h0, sOut}, {13'h0, sDrv});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    seed = 32'hc14ded50;
    {rst_n, drv, sDrv, autoNeg, phyPs} = '0;
    {cableEnergy, cableConn} = 2'b11;
    {num_errors, comparisons} = '0;
    // Random straps latched across repeated resets.
    for (int i = 0; i < 4; i++) begin
      drv = 3'($random(seed));
      sDrv = 3'($random(seed));
      doReset();
      rdx(8'h08, {5'h0, drv[2:1], 1'b0, drv[0], ~drv[0], 6'h0});
      check("bigEndian_r", {15'h0, bigEndian_r}, {15'h0, drv[2]});
    end
    drv = 3'h0;
    doReset();
    rdx(8'hD4, 16'h0000);
    rdx(8'h00, 16'h0000);
    waitObs(8'h3F, 8'h33);
    pmsc_host_model_i.wr(8'h86, 16'h0800);
    waitObs(8'h3F, 8'h33);
    check("bigEndian_r", {15'h0, bigEndian_r}, 16'h0001);
    $display("strap test done");
    // Power saving with and without its conditions.
    {autoNeg, cableConn, phyPs} = 3'b101;
    pmsc_host_model_i.wr(8'hD4, 16'h0003);
    waitObs(8'h3F, 8'h3B);
    cableConn = 1'b1;
    waitObs(8'h3F, 8'h33);
    // Soft power down keeps registers and refuses writes.
    pmsc_host_model_i.wr(8'h90, 16'h0004);
    pmsc_host_model_i.wr(8'hD4, 16'h0002);
    waitObs(8'h3F, 8'h00);
    pmsc_host_model_i.wr(8'h90, 16'h0000);
    rdx(8'h26, 16'h0000);
    waitObs(8'h3F, 8'h33);
    rdx(8'hD4, 16'h0000);
    rdx(8'h90, 16'h0004);
    $display("mode test done");
    // Energy detect: sleep, auto wake, event outputs.
    pmsc_host_model_i.wr(8'hD6, 16'h0101);
    pmsc_host_model_i.wr(8'hD4, 16'h0181);
    cableEnergy = 1'b0;
    waitObs(8'h3F, 8'h04);
    rdx(8'hD4, 16'h0000);
    cableEnergy = 1'b1;
    waitObs(8'h3F, 8'h37);
    waitObs(8'hC0, 8'hC0);
    rdx(8'h26, 16'h0000);
    waitObs(8'hC0, 8'h00);
    // Without auto wake only the reset-register read wakes.
    pmsc_host_model_i.wr(8'hD4, 16'h0101);
    cableEnergy = 1'b0;
    waitObs(8'h3F, 8'h04);
    cableEnergy = 1'b1;
    repeat (40) @(negedge clk_sys);
    check("enables", {10'h0, en}, 16'h0004);
    rdx(8'h26, 16'h0000);
    waitObs(8'h3F, 8'h37);
    // Auto wake with bit 6 returns the mode field to normal.
    pmsc_host_model_i.wr(8'hD4, 16'h00C1);
    cableEnergy = 1'b0;
    waitObs(8'h3F, 8'h04);
    cableEnergy = 1'b1;
    waitObs(8'h3F, 8'h33);
    rdx(8'hD4, 16'h00C0);
    repeat (3) @(negedge clk_sys);
    $display("energy test done");
    finish_test();
  end
endmodule
